// ===== inc/crp_pkg.sv
// Constants, register map and types of the clock, reset and power controller
package crp_pkg;

	localparam int unsigned CLK_NS       = 5;
	localparam int unsigned RST_PULSE_NS = 50;
	// A 50 ns pulse gives at least this many samples plus two
	localparam logic [3:0]  RST_FILT_CYC = 4'((RST_PULSE_NS + CLK_NS - 1) / CLK_NS - 2);
	localparam logic [7:0]  CHIP_RST_CYC = 8'h10;

	localparam int unsigned APB_AW = 8;
	localparam logic [7:0] A_CLKSEL  = 8'h00;
	localparam logic [7:0] A_PLLCTRL = 8'h04;
	localparam logic [7:0] A_CLOCK_OUTPUT_FUNCTION  = 8'h08;
	localparam logic [7:0] A_GATE    = 8'h0C;
	localparam logic [7:0] A_PWRMODE = 8'h10;
	localparam logic [7:0] A_WAKEEN  = 8'h14;
	localparam logic [7:0] A_OSCCTRL = 8'h18;
	localparam logic [7:0] A_BODCTRL = 8'h1C;
	localparam logic [7:0] A_STATUS  = 8'h20;
	localparam logic [7:0] A_WKT     = 8'h24;
	localparam logic [7:0] A_RETAIN0 = 8'h30;
	localparam logic [7:0] A_RETAIN3 = 8'h3C;

	localparam int unsigned NUM_PERIPH = 16;
	localparam int unsigned NUM_WAKE   = 5;
	localparam int unsigned NUM_RETAIN = 4;
	localparam int unsigned NUM_BOD    = 4;

	// Wake source positions
	localparam int unsigned WK_PININT = 0;
	localparam int unsigned WK_WDT    = 1;
	localparam int unsigned WK_USART  = 2;
	localparam int unsigned WK_SPI    = 3;
	localparam int unsigned WK_I2C    = 4;

	// Reset cause positions
	localparam int unsigned RC_PIN = 0;
	localparam int unsigned RC_WDT = 1;
	localparam int unsigned RC_POR = 2;
	localparam int unsigned RC_BOD = 3;
	localparam int unsigned RC_DPD = 4;
	localparam int unsigned NUM_CAUSE = 5;

	// PLL control fields: mult-1 [4:0], divider select [6:5], enable [7], bypass [8]
	localparam int unsigned PLL_W       = 9;
	localparam int unsigned PLL_DIV_LSB = 5;
	localparam int unsigned PLL_EN_BIT  = 7;
	localparam int unsigned PLL_BYP_BIT = 8;
	localparam logic [8:0]  PLL_RST     = 9'h100;

	// Oscillator enable bits
	localparam int unsigned OSC_XTAL = 0;
	localparam int unsigned OSC_EXT  = 1;
	localparam int unsigned OSC_WD   = 2;
	localparam int unsigned OSC_LP   = 3;
	localparam logic [3:0]  OSC_RST  = 4'h0;

	// Brownout control: irq level [1:0], reset level [3:2], reset enable [4]
	localparam int unsigned BOD_RST_EN_BIT = 4;
	localparam logic [4:0]  BOD_RST        = 5'h00;

	localparam logic [15:0] GATE_RST    = 16'hFFFF;
	localparam logic [31:0] BOOT_VECTOR = 32'h0000_0000;

	typedef enum logic [1:0] {SRC_IRC = 2'b00, SRC_XTAL = 2'b01, SRC_EXT = 2'b10, SRC_PLL = 2'b11} crp_sysclk_t;
	typedef enum logic [1:0] {CO_IRC = 2'b00, CO_XTAL = 2'b01, CO_WATCHDOG_OSC = 2'b10, CO_MAIN = 2'b11} crp_clock_output_function_t;
	typedef enum logic [2:0] {
		PM_ACTIVE = 3'b000,
		PM_SLEEP  = 3'b001,
		PM_DSLEEP = 3'b010,
		PM_PDOWN  = 3'b011,
		PM_DPD    = 3'b100
	} crp_pmode_t;

	function automatic logic [5:0] crp_pll_mult(input logic [4:0] field);
		crp_pll_mult = {1'b0, field} + 6'h01;
	endfunction

	function automatic logic [4:0] crp_pll_div(input logic [1:0] sel);
		crp_pll_div = 5'h02 << sel;
	endfunction

endpackage

// ===== rtl/crp_ctrl.sv
// Clock source, PLL, gating, power mode and reset controller with APB registers
//
// Behaviour
// - Reset selects the internal RC oscillator as system clock until software changes it.
// - PLL multiplier takes any integer 1 to 32.
// - PLL post divider offers only 2, 4, 8 or 16.
// - PLL powered off and bypassed after any chip reset.
// - Clock output selects RC, crystal, watchdog oscillator or main clock.
// - One clock gate per peripheral, software controlled.
// - Sleep stops only the core clock; peripherals keep running.
// - Sleep lasts until reset or interrupt; exit just restarts core clock.
// - Deep-sleep keeps only RC and chosen low-power oscillators; RC output blocked.
// - Deep-sleep exits on reset, pin, watchdog, USART, SPI or I2C interrupt.
// - Wake needs both wake enable and core interrupt enable.
// - Power-down keeps only chosen low-power oscillators; analog and flash off.
// - Deep power-down keeps wake pin, wake timer and four retention registers.
// - Deep power-down ends on wake pin or wake timer time-out.
// - Lock bit refuses entry to deep power-down.
// - Chip reset from pin, watchdog, power-on or brownout.
// - Any chip reset starts RC oscillator and initialises flash controller.
// - Reset pin low for 50 ns or longer is a valid reset.
// - After reset registers hold defaults and core boots from address zero.
// - Brownout below chosen level raises an interrupt, also readable.
// - Brownout below chosen level may force full chip reset.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module crp_ctrl
	import crp_pkg::*;
(
	input  wire logic                  clock,           // System clock
	input  wire logic                  sys_rst,         // Synchronous reset, high
	input  wire logic                  psel,            // APB select
	input  wire logic                  penable,         // APB enable
	input  wire logic                  pwrite,          // APB write
	input  wire logic [APB_AW-1:0]     paddr,           // APB byte address
	input  wire logic [31:0]           pwdata,          // APB write data
	output logic      [31:0]           prdata,          // APB read data
	output logic                       pready,          // APB ready
	output logic                       pslverr,         // APB error
	input  wire logic                  rst_pin_n,       // External reset pin
	input  wire logic                  por_n,           // Power-on detector, low in reset
	input  wire logic                  wdt_rst,         // Watchdog reset request
	input  wire logic [NUM_BOD-1:0]    bod_below,       // Supply below each brownout level
	input  wire logic [NUM_WAKE-1:0]   wake_req,        // Peripheral wake requests
	input  wire logic [NUM_WAKE-1:0]   core_interrupt_controller_en,         // Core interrupt enables of wake sources
	input  wire logic                  irq_pending,     // Any enabled core interrupt pending
	input  wire logic                  wake_pin_n,      // Dedicated wake pin, low wakes
	input  wire logic                  pll_lock,        // PLL lock from analog
	output logic                       chip_rst,        // Chip reset to core and peripherals
	output logic                       flash_init,      // Flash controller initialisation
	output logic      [31:0]           boot_addr,       // Core fetch address after reset
	output logic                       core_clk_en,     // Core clock enable
	output logic      [NUM_PERIPH-1:0] periph_clk_en,   // Peripheral clock enables
	output logic      [1:0]            sys_clk_sel,     // Main clock source
	output logic      [1:0]            clock_output_function_sel,      // Clock output source
	output logic      [5:0]            pll_mult,        // PLL feedback multiplier
	output logic      [4:0]            pll_div,         // PLL post divider ratio
	output logic                       pll_pd,          // PLL power down
	output logic                       pll_bypass,      // PLL bypass
	output logic                       irc_en,          // RC oscillator running
	output logic                       irc_out_en,      // RC oscillator output passed
	output logic                       xtal_en,         // Crystal oscillator enable
	output logic                       ext_clk_en,      // External clock input enable
	output logic                       watchdog_osc_en,        // Watchdog oscillator enable
	output logic                       lposc_en,        // Low-power oscillator enable
	output logic                       analog_pd,       // Analog blocks shut down
	output logic                       flash_standby,   // Flash standby
	output logic                       flash_pd,        // Flash shut down
	output logic                       power_off,       // Main power domain off
	output logic                       bod_irq          // Brownout interrupt request
);

	localparam int unsigned SYW = NUM_WAKE + NUM_BOD + 4;

	// Synchronisers for pin and analog inputs
	logic [SYW-1:0] sy1_q;
	logic [SYW-1:0] sy2_q;
	logic [SYW-1:0] sy_in;
	logic [SYW-1:0] sy_rst;

	assign sy_in  = {pll_lock, wake_pin_n, por_n, rst_pin_n, bod_below, wake_req};
	assign sy_rst = {1'b0, 1'b1, 1'b1, 1'b1, {NUM_BOD{1'b0}}, {NUM_WAKE{1'b0}}};

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sy1_q <= sy_rst;
			sy2_q <= sy_rst;
		end else begin
			sy1_q <= sy_in;
			sy2_q <= sy1_q;
		end
	end

	wire logic [NUM_WAKE-1:0] wake_s     = sy2_q[NUM_WAKE-1:0];
	wire logic [NUM_BOD-1:0]  below_s    = sy2_q[NUM_WAKE +: NUM_BOD];
	wire logic                pin_n_s    = sy2_q[NUM_WAKE + NUM_BOD];
	wire logic                por_n_s    = sy2_q[NUM_WAKE + NUM_BOD + 1];
	wire logic                wkpin_n_s  = sy2_q[NUM_WAKE + NUM_BOD + 2];
	wire logic                lock_s     = sy2_q[NUM_WAKE + NUM_BOD + 3];

	// Registers
	logic [1:0]            clksel_q;
	logic [PLL_W-1:0]      pll_q;
	logic [1:0]            clock_output_function_q;
	logic [NUM_PERIPH-1:0] gate_q;
	logic                  lock_q;
	logic [NUM_WAKE-1:0]   wake_en_q;
	logic [3:0]            osc_q;
	logic [4:0]            bod_q;
	logic [NUM_CAUSE-1:0]  cause_q;
	logic                  dpd_ref_q;
	logic                  wkt_to_q;
	logic [31:0]           wkt_q;
	logic [31:0]           retain_q [NUM_RETAIN];
	logic [31:0]           prdata_q;
	crp_pmode_t            pm_q;
	crp_pmode_t            pm_d;
	logic [3:0]            flt_q;
	logic [7:0]            rcnt_q;
	logic                  chip_rst_q;

	// APB decode
	wire logic       setup_rd = psel & ~penable & ~pwrite;
	wire logic       acc      = psel & penable;
	wire logic       wr       = acc & pwrite;
	wire logic [7:0] a        = paddr;
	wire logic       hit_ret  = (a >= A_RETAIN0) && (a <= A_RETAIN3) && (a[1:0] == 2'b00);
	wire logic [1:0] ret_idx  = a[3:2];
	wire logic       hit      = hit_ret || a == A_CLKSEL || a == A_PLLCTRL || a == A_CLOCK_OUTPUT_FUNCTION || a == A_GATE
	                            || a == A_PWRMODE || a == A_WAKEEN || a == A_OSCCTRL || a == A_BODCTRL
	                            || a == A_STATUS || a == A_WKT;
	wire logic       wr_clksel = wr && a == A_CLKSEL;
	wire logic       wr_pll    = wr && a == A_PLLCTRL;
	wire logic       wr_clock_output_function = wr && a == A_CLOCK_OUTPUT_FUNCTION;
	wire logic       wr_gate   = wr && a == A_GATE;
	wire logic       wr_pwr    = wr && a == A_PWRMODE;
	wire logic       wr_wake   = wr && a == A_WAKEEN;
	wire logic       wr_osc    = wr && a == A_OSCCTRL;
	wire logic       wr_bod    = wr && a == A_BODCTRL;
	wire logic       wr_stat   = wr && a == A_STATUS;
	wire logic       wr_wkt    = wr && a == A_WKT;
	wire logic       wr_ret    = wr && hit_ret;

	// Mode request field of the power mode register; bit 3 is the lock
	wire logic [2:0] req_mode = pwdata[2:0];
	wire logic       req_dpd  = wr_pwr && req_mode == PM_DPD;
	wire logic       dpd_lock = lock_q | (wr_pwr & pwdata[3]);

	// Mode groups
	wire logic run_mode  = pm_q == PM_ACTIVE || pm_q == PM_SLEEP;
	wire logic deep_mode = pm_q == PM_DSLEEP || pm_q == PM_PDOWN;

	// Wake qualification
	wire logic deep_wake = |(wake_s & wake_en_q & core_interrupt_controller_en);
	wire logic wkt_fire  = wkt_q == 32'h0000_0001;
	wire logic dpd_wake  = pm_q == PM_DPD && (~wkpin_n_s || wkt_fire || wkt_to_q);

	// Reset sources
	wire logic pin_rst = ~pin_n_s && flt_q == RST_FILT_CYC;
	wire logic bod_rst = bod_q[BOD_RST_EN_BIT] & below_s[bod_q[3:2]];
	wire logic src_rst = pin_rst | wdt_rst | ~por_n_s | bod_rst | dpd_wake;
	wire logic rst_any = sys_rst | chip_rst_q;

	// Reset pin glitch filter
	always_ff @(posedge clock) begin
		if (sys_rst || pin_n_s) begin
			flt_q <= 4'h0;
		end else if (flt_q != RST_FILT_CYC) begin
			flt_q <= flt_q + 4'h1;
		end
	end

	// Chip reset stretch; RC runs and flash initialises throughout
	always_ff @(posedge clock) begin
		if (sys_rst || src_rst) begin
			rcnt_q     <= CHIP_RST_CYC;
			chip_rst_q <= 1'b1;
		end else begin
			if (rcnt_q != 8'h00) begin
				rcnt_q <= rcnt_q - 8'h01;
			end
			chip_rst_q <= rcnt_q > 8'h01;
		end
	end

	// Reset causes survive chip reset; a new cause beats a clear
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cause_q <= '0;
		end else begin
			cause_q <= (cause_q & ~({NUM_CAUSE{wr_stat}} & pwdata[8 +: NUM_CAUSE]))
			           | {dpd_wake, bod_rst, ~por_n_s, wdt_rst, pin_rst};
		end
	end

	// Clock configuration, reset to RC, PLL off and bypassed
	always_ff @(posedge clock) begin
		if (rst_any) begin
			clksel_q <= SRC_IRC;
			pll_q    <= PLL_RST;
			clock_output_function_q <= CO_IRC;
			gate_q   <= GATE_RST;
			osc_q    <= OSC_RST;
		end else begin
			if (wr_clksel) begin
				clksel_q <= pwdata[1:0];
			end
			if (wr_pll) begin
				pll_q <= pwdata[PLL_W-1:0];
			end
			if (wr_clock_output_function) begin
				clock_output_function_q <= pwdata[1:0];
			end
			if (wr_gate) begin
				gate_q <= pwdata[NUM_PERIPH-1:0];
			end
			if (wr_osc) begin
				osc_q <= pwdata[3:0];
			end
		end
	end

	// Power control registers
	always_ff @(posedge clock) begin
		if (rst_any) begin
			lock_q    <= 1'b0;
			wake_en_q <= '0;
			bod_q     <= BOD_RST;
			dpd_ref_q <= 1'b0;
		end else begin
			if (wr_pwr) begin
				lock_q <= lock_q | pwdata[3];
			end
			if (wr_wake) begin
				wake_en_q <= pwdata[NUM_WAKE-1:0];
			end
			if (wr_bod) begin
				bod_q <= pwdata[4:0];
			end
			if (req_dpd && dpd_lock) begin
				dpd_ref_q <= 1'b1;
			end else if (wr_stat && pwdata[16]) begin
				dpd_ref_q <= 1'b0;
			end
		end
	end

	// Self wake timer and retention live in the always-on domain
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wkt_q    <= 32'h0000_0000;
			wkt_to_q <= 1'b0;
		end else begin
			if (wr_wkt) begin
				wkt_q <= pwdata;
			end else if (wkt_q != 32'h0000_0000) begin
				wkt_q <= wkt_q - 32'h0000_0001;
			end
			if (wkt_fire) begin
				wkt_to_q <= 1'b1;
			end else if (wr_stat && pwdata[17]) begin
				wkt_to_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_RETAIN; i++) begin
				retain_q[i] <= 32'h0000_0000;
			end
		end else if (wr_ret) begin
			retain_q[ret_idx] <= pwdata;
		end
	end

	// Power mode sequencer; deep power-down leaves through chip reset
	always_comb begin
		pm_d = pm_q;
		unique case (pm_q)
			PM_ACTIVE: begin
				if (wr_pwr) begin
					unique case (req_mode)
						PM_SLEEP:  pm_d = PM_SLEEP;
						PM_DSLEEP: pm_d = PM_DSLEEP;
						PM_PDOWN:  pm_d = PM_PDOWN;
						PM_DPD:    pm_d = dpd_lock ? PM_ACTIVE : PM_DPD;
						default:   pm_d = PM_ACTIVE;
					endcase
				end
			end
			PM_SLEEP: begin
				if (irq_pending) begin
					pm_d = PM_ACTIVE;
				end
			end
			PM_DSLEEP, PM_PDOWN: begin
				if (deep_wake) begin
					pm_d = PM_ACTIVE;
				end
			end
			PM_DPD: begin
				pm_d = PM_DPD;
			end
			default: begin
				pm_d = PM_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst_any) begin
			pm_q <= PM_ACTIVE;
		end else begin
			pm_q <= pm_d;
		end
	end

	// Read mux sampled in setup phase so read data comes from a register
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ret) begin
			rd_mux = retain_q[ret_idx];
		end else begin
			unique case (a)
				A_CLKSEL:  rd_mux = {30'h0, clksel_q};
				A_PLLCTRL: rd_mux = {23'h0, pll_q};
				A_CLOCK_OUTPUT_FUNCTION:  rd_mux = {30'h0, clock_output_function_q};
				A_GATE:    rd_mux = {16'h0, gate_q};
				A_PWRMODE: rd_mux = {28'h0, lock_q, pm_q};
				A_WAKEEN:  rd_mux = {27'h0, wake_en_q};
				A_OSCCTRL: rd_mux = {28'h0, osc_q};
				A_BODCTRL: rd_mux = {27'h0, bod_q};
				A_STATUS:  rd_mux = {14'h0, wkt_to_q, dpd_ref_q, 3'h0, cause_q, 6'h0, lock_s, bod_irq};
				A_WKT:     rd_mux = wkt_q;
				default:   rd_mux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup_rd) begin
			prdata_q <= rd_mux;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = acc & ~hit;

	// Reset and boot
	assign chip_rst   = chip_rst_q;
	assign flash_init = chip_rst_q;
	assign boot_addr  = BOOT_VECTOR;

	// Clock and power outputs follow the mode
	assign core_clk_en   = pm_q == PM_ACTIVE && ~chip_rst_q;
	assign periph_clk_en = gate_q & {NUM_PERIPH{run_mode}};
	assign sys_clk_sel   = clksel_q;
	assign clock_output_function_sel    = clock_output_function_q;
	assign pll_mult      = crp_pll_mult(pll_q[4:0]);
	assign pll_div       = crp_pll_div(pll_q[PLL_DIV_LSB +: 2]);
	assign pll_pd        = ~pll_q[PLL_EN_BIT] | ~run_mode;
	assign pll_bypass    = pll_q[PLL_BYP_BIT];
	assign irc_en        = chip_rst_q | run_mode | pm_q == PM_DSLEEP;
	assign irc_out_en    = run_mode;
	assign xtal_en       = osc_q[OSC_XTAL] & run_mode;
	assign ext_clk_en    = osc_q[OSC_EXT] & run_mode;
	assign watchdog_osc_en      = osc_q[OSC_WD] & pm_q != PM_DPD;
	assign lposc_en      = osc_q[OSC_LP] | pm_q == PM_DPD;
	assign analog_pd     = ~run_mode;
	assign flash_standby = pm_q == PM_DSLEEP;
	assign flash_pd      = pm_q == PM_PDOWN || pm_q == PM_DPD;
	assign power_off     = pm_q == PM_DPD;
	assign bod_irq       = below_s[bod_q[1:0]];

endmodule

`default_nettype wire

// ===== dv/crp_src_model.sv
// Wake and interrupt sources standing beside the controller
`timescale 1ns/10ps
`default_nettype none

module crp_src_model (
	input  wire logic       clock,       // System clock
	input  wire logic       sys_rst,     // Reset, high
	input  wire logic       core_clk_en, // Core running
	input  wire logic [4:0] wake_cmd,    // Bench raises a wake source
	input  wire logic       irq_cmd,     // Bench raises an interrupt
	output logic      [4:0] wake_req,    // Wake requests
	output logic            irq_pending  // Pending interrupt
);
	// Flags hold until the core runs again, as a real peripheral does
	always_ff @(posedge clock) begin
		if (sys_rst || core_clk_en) begin
			wake_req <= 5'h00;
			irq_pending <= 1'b0;
		end else begin
			wake_req <= wake_req | wake_cmd;
			irq_pending <= irq_pending | irq_cmd;
		end
	end
endmodule

`default_nettype wire

// ===== dv/crp_ctrl_chk.sv
// Concurrent checks on the controller ports
`timescale 1ns/10ps
`default_nettype none

module crp_ctrl_chk (
	input wire logic        clock,         // Clock
	input wire logic        sys_rst,       // Reset
	input wire logic        wdt_rst,       // Watchdog request
	input wire logic        irq_pending,   // Pending interrupt
	input wire logic [4:0]  core_interrupt_controller_en,       // Core enables
	input wire logic        chip_rst,      // Chip reset
	input wire logic        flash_init,    // Flash init
	input wire logic [31:0] boot_addr,     // Boot address
	input wire logic        core_clk_en,   // Core clock
	input wire logic [15:0] periph_clk_en, // Peripheral clocks
	input wire logic [1:0]  sys_clk_sel,   // Main source
	input wire logic [5:0]  pll_mult,      // Multiplier
	input wire logic [4:0]  pll_div,       // Divider
	input wire logic        pll_pd,        // PLL off
	input wire logic        pll_bypass,    // PLL bypass
	input wire logic        irc_en,        // RC running
	input wire logic        irc_out_en,    // RC output
	input wire logic        xtal_en,       // Crystal
	input wire logic        analog_pd,     // Analog off
	input wire logic        flash_standby, // Flash standby
	input wire logic        flash_pd,      // Flash off
	input wire logic        power_off      // Main domain off
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_rst_defaults: assert property ($fell(chip_rst) |-> sys_clk_sel == 2'h0 && pll_pd && pll_bypass)
		else $error("clock source or PLL not at defaults after reset");
	a_rst_starts: assert property (chip_rst |-> flash_init && irc_en && !core_clk_en)
		else $error("reset did not start RC or flash init");
	a_boot_zero: assert property ($fell(chip_rst) |-> boot_addr == 32'h0000_0000)
		else $error("boot address not zero");
	a_pll_mult: assert property (pll_mult >= 6'h01 && pll_mult <= 6'h20)
		else $error("multiplier out of range");
	a_pll_div: assert property ($onehot(pll_div) && !pll_div[0])
		else $error("divider not 2, 4, 8 or 16");
	a_sleep_keep: assert property ($fell(core_clk_en) && irc_out_en && !chip_rst |-> $stable(periph_clk_en))
		else $error("sleep changed peripheral clocks");
	a_sleep_exit: assert property (!core_clk_en && irc_out_en && !chip_rst && irq_pending
		|-> ##[1:2] (core_clk_en || chip_rst))
		else $error("interrupt did not end sleep");
	a_dsleep_off: assert property (flash_standby |-> !irc_out_en && irc_en && periph_clk_en == 16'h0000
		&& !xtal_en && analog_pd)
		else $error("deep-sleep left clocks on");
	a_pdown_off: assert property (flash_pd && !chip_rst |-> !irc_en && periph_clk_en == 16'h0000
		&& !xtal_en && analog_pd)
		else $error("power-down left clocks on");
	a_dpd_keep: assert property (power_off |-> !core_clk_en && flash_pd && analog_pd)
		else $error("deep power-down left logic powered");
	a_wake_gate: assert property (flash_standby && core_interrupt_controller_en == 5'h00 |=> flash_standby || chip_rst)
		else $error("disabled source woke deep-sleep");
	a_wdt_reset: assert property (wdt_rst |-> ##[1:3] chip_rst)
		else $error("watchdog did not reset chip");

	c_sleep_wake: cover property (!core_clk_en && irc_out_en ##1 core_clk_en);
	c_dsleep: cover property (flash_standby);
	c_dpd: cover property (power_off);
endmodule

bind crp_ctrl crp_ctrl_chk u_chk (.*);

`default_nettype wire

// ===== dv/crp_ctrl_bench.sv
// Self-checking bench of the clock, reset and power controller
`timescale 1ns/10ps
`default_nettype none

module crp_ctrl_bench import crp_pkg::*;;
	logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, err;
	logic        rst_pin_n, por_n, wdt_rst, wake_pin_n, pll_lock, irq_cmd, irq_pending;
	logic        chip_rst, flash_init, core_clk_en, pll_pd, pll_bypass, irc_en, irc_out_en;
	logic        xtal_en, ext_clk_en, watchdog_osc_en, lposc_en, analog_pd, flash_standby, flash_pd;
	logic        power_off, bod_irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, boot_addr;
	logic [3:0]  bod_below;
	logic [4:0]  wake_req, core_interrupt_controller_en, wake_cmd, pll_div;
	logic [15:0] periph_clk_en;
	logic [1:0]  sys_clk_sel, clock_output_function_sel;
	logic [5:0]  pll_mult;
	int          error_cnt, checks_done, cyc;

	crp_ctrl dut (.*);
	crp_src_model u_src (.*);

	always #2.5 clock = ~clock;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			error_cnt++;
			end_of_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Ends one edge after release so the write's effect is visible
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wt(input bit core, input logic lvl);
		int n;
		n = 0;
		while ((core ? core_clk_en : chip_rst) !== lvl && n < 300) begin
			@(posedge clock);
			n++;
		end
	endtask

	task automatic pulse_wake(input logic [4:0] v);
		wake_cmd <= v;
		@(posedge clock);
		wake_cmd <= 5'h00;
	endtask

	initial begin
		clock = 1'b0;
		cyc = 0;
		error_cnt = 0;
		checks_done = 0;
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		{rst_pin_n, por_n, wake_pin_n} = 3'b111;
		{wdt_rst, pll_lock, irq_cmd} = 3'b000;
		bod_below = 4'h0;
		core_interrupt_controller_en = 5'h00;
		wake_cmd = 5'h00;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		chk("rst_start", {chip_rst, flash_init, irc_en}, 3'b111);
		wt(0, 1'b0);
		chk("sys_clk_sel", sys_clk_sel, SRC_IRC);
		chk("pll_off", {pll_bypass, pll_pd}, 2'b11);
		chk("boot_addr", boot_addr, BOOT_VECTOR);
		apb(0, A_PLLCTRL, 0);
		chk("pllctrl", rd, PLL_RST);
		apb(0, A_GATE, 0);
		chk("gate", rd, GATE_RST);
		$display("test reset done");

		for (int j = 0; j < 8; j++) begin
			apb(1, A_PLLCTRL, 32'h80 | ((j % 4) << 5) | ((j / 4) * 31));
			chk("pll_mult", pll_mult, (j / 4) * 31 + 1);
			chk("pll_div", pll_div, 2 << (j % 4));
			chk("pll_on", {pll_bypass, pll_pd}, 2'b00);
		end
		pll_lock <= 1'b1;
		rd = 32'h0000_0000;
		while (rd[1] !== 1'b1) apb(0, A_STATUS, 0);
		apb(1, A_CLKSEL, SRC_PLL);
		chk("sys_clk_sel", sys_clk_sel, SRC_PLL);
		for (int k = 0; k < 4; k++) begin
			apb(1, A_CLOCK_OUTPUT_FUNCTION, k);
			chk("clock_output_function_sel", clock_output_function_sel, k);
		end
		apb(1, A_GATE, 32'h0000_A5A5);
		chk("periph_clk_en", periph_clk_en, 16'hA5A5);
		$display("test clocks done");

		apb(1, A_PWRMODE, PM_SLEEP);
		repeat (10) @(posedge clock);
		chk("core_clk_en", core_clk_en, 0);
		chk("periph_clk_en", periph_clk_en, 16'hA5A5);
		irq_cmd <= 1'b1;
		@(posedge clock);
		irq_cmd <= 1'b0;
		wt(1, 1'b1);
		chk("core_clk_en", core_clk_en, 1);
		// Sources 0 and 1 each blocked by one of the two enables
		apb(1, A_WAKEEN, 32'h1D);
		core_interrupt_controller_en <= 5'h1E;
		apb(1, A_PWRMODE, PM_DSLEEP);
		pulse_wake(5'h03);
		repeat (20) @(posedge clock);
		chk("core_clk_en", core_clk_en, 0);
		// All five core enables off while a wake is pending
		core_interrupt_controller_en <= 5'h00;
		repeat (3) @(posedge clock);
		chk("core_clk_en", core_clk_en, 0);
		core_interrupt_controller_en <= 5'h1F;
		wt(1, 1'b1);
		chk("core_clk_en", core_clk_en, 1);
		apb(1, A_WAKEEN, 32'h1F);
		apb(1, A_OSCCTRL, 32'h0F);
		for (int k = 0; k < 5; k++) begin
			apb(1, A_PWRMODE, (k % 2) ? PM_PDOWN : PM_DSLEEP);
			repeat (2) @(posedge clock);
			chk("lp_outs", {flash_standby, flash_pd, irc_en, irc_out_en}, (k % 2) ? 4'h4 : 4'hA);
			chk("periph_clk_en", periph_clk_en, 16'h0000);
			chk("osc_lp", {xtal_en, ext_clk_en, watchdog_osc_en, lposc_en}, 4'h3);
			pulse_wake(5'h01 << k);
			wt(1, 1'b1);
			chk("core_clk_en", core_clk_en, 1);
		end
		apb(0, 8'h2C, 0);
		chk("pslverr", err, 1);
		chk("prdata", rd, 0);
		$display("test sleep done");

		apb(1, A_BODCTRL, 32'h02);
		bod_below <= 4'h4;
		repeat (5) @(posedge clock);
		chk("bod_irq", bod_irq, 1);
		apb(0, A_STATUS, 0);
		chk("bod_status", rd[0], 1);
		// Source 0 is a pin pulse too short to count
		for (int k = 0; k < 5; k++) begin
			apb(1, A_CLKSEL, SRC_XTAL);
			apb(1, A_PLLCTRL, 32'h80);
			if (k == 4) apb(1, A_BODCTRL, 32'h1A);
			rst_pin_n <= (k > 1);
			wdt_rst <= (k == 2);
			por_n <= (k != 3);
			bod_below <= (k == 4) ? 4'h4 : 4'h0;
			repeat ((k == 0) ? 4 : 10) @(posedge clock);
			{rst_pin_n, por_n, wdt_rst} <= 3'b110;
			// Look inside the 16-cycle stretch
			repeat (5) @(posedge clock);
			chk("chip_rst", chip_rst, k != 0);
			bod_below <= 4'h0;
			wt(0, 1'b0);
			if (k != 0) begin
				chk("sys_clk_sel", sys_clk_sel, SRC_IRC);
				chk("pll_off", {pll_bypass, pll_pd}, 2'b11);
				apb(0, A_STATUS, 0);
				chk("cause", rd[7 + k], 1);
			end
		end
		$display("test resets done");

		for (int i = 0; i < 2; i++) begin
			apb(1, i ? A_RETAIN3 : A_RETAIN0, 32'hC0DE_0000 + i);
			if (i) apb(1, A_WKT, 32'h40);
			apb(1, A_PWRMODE, PM_DPD);
			@(posedge clock);
			chk("power_off", {power_off, lposc_en}, 2'b11);
			wake_pin_n <= (i != 0);
			wt(0, 1'b1);
			wake_pin_n <= 1'b1;
			wt(0, 1'b0);
			apb(0, i ? A_RETAIN3 : A_RETAIN0, 0);
			chk("retain", rd, 32'hC0DE_0000 + i);
			apb(0, A_STATUS, 0);
			chk("dpd_wake", i ? rd[17] : rd[12], 1);
		end
		// Stale timeout flag would wake a wrongly entered deep power-down
		apb(1, A_STATUS, 32'h0002_0000);
		apb(1, A_PWRMODE, 32'h0C);
		repeat (3) @(posedge clock);
		chk("power_off", power_off, 0);
		apb(0, A_STATUS, 0);
		chk("dpd_refused", rd[16], 1);
		apb(0, A_PWRMODE, 0);
		chk("lock", rd[3], 1);
		$display("test power_down done");
		end_of_test();
	end
endmodule

`default_nettype wire
